// ==== hdl/icfm_pkg.sv ====
// package: register map, field layout, resets and timing for the clock monitor
package icfm_pkg;
    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_LINK_CFG = 8'h5c;
    localparam logic [7:0] ADDR_LOW_LIM = 8'h5d;
    localparam logic [7:0] ADDR_HIGH_LIM = 8'h5e;
    localparam logic [7:0] ADDR_MEAS = 8'h5f;
    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int BIT_SWAP_FIX_DIS = 7;
    localparam int BIT_LINK_RDY_OVR = 6;
    localparam int BIT_CLK_PRES_OVR = 5;
    localparam int BIT_PHY_RST_MODE = 6;
    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_LINK_CFG = 8'h02;
    localparam logic [7:0] RST_LOW_LIM = 8'h06;
    localparam logic [7:0] RST_HIGH_LIM = 8'h2c;
    localparam logic [7:0] RST_MEAS = 8'h00;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 25;
    localparam int STBL_US_0 = 40;
    localparam int STBL_US_1 = 80;
    localparam int STBL_US_2 = 320;
    localparam int STBL_US_3 = 1280;
    localparam int STBL_CYC_0 = STBL_US_0 * CLK_MHZ;
    localparam int STBL_CYC_1 = STBL_US_1 * CLK_MHZ;
    localparam int STBL_CYC_2 = STBL_US_2 * CLK_MHZ;
    localparam int STBL_CYC_3 = STBL_US_3 * CLK_MHZ;
    localparam int MEAS_US = 1;
    localparam int MEAS_CYC = MEAS_US * CLK_MHZ;

    // register bus request: strobes, address and write data
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } icfm_req_t;

    // status to the rest of the bridge
    typedef struct packed {
        logic clk_valid;
        logic link_ready;
        logic swap_state;
        logic phy_reset;
        logic pll_reset;
        logic meter_sel;
    } icfm_stat_t;
endpackage

// ==== hdl/icfm_monitor.sv ====
// input clock frequency monitor with its control and status registers
`timescale 1ns/10ps

//Contract
// - swap fix disable stops auto swap correction and lets software write swap.
// - link ready override reports link ready without back channel detection.
// - clock present override forces clock valid regardless of checks.
// - window select 00/01/10/11 gives 40us/80us/320us/1.28ms stability.
// - stable only after measurement held in band for whole window.
// - capture new value only when difference exceeds hysteresis MHz.
// - phy reset on change, skipped when policy set and +5V present.
// - below low limit the clock is too slow.
// - seven-bit high limit is upper threshold of clock check.
// - read-only measured rate, zero when no valid signal.
// - swap state shows correction, writable only with auto fix disabled.
// - pll reset on change bit resets link pll on frequency change.
// - meter source select picks raw clock or pll clock.
module icfm_monitor #(
    parameter int STBL_CYC_3 = icfm_pkg::STBL_CYC_3
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // register port
    input wire icfm_pkg::icfm_req_t reg_req,
    output logic [7:0] reg_rdata,
    // measurement inputs (pins, not synchronous)
    input wire logic raw_clk_tick,
    input wire logic pll_clk_tick,
    input wire logic plus5v_det,
    input wire logic back_channel_det,
    input wire logic swap_detected,
    input wire logic pll_reset_on_change,
    input wire logic meter_source_sel,
    // status
    output icfm_pkg::icfm_stat_t status
);
    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [7:0] link_override_cfg_reg;
    logic [6:0] low_limit_reg;
    logic [6:0] high_limit_reg;
    logic [7:0] measured_clock_mhz_reg;
    logic swap_state_reg;
    logic [7:0] rdata_reg;
    icfm_pkg::icfm_stat_t status_reg;

    wire swap_fix_dis = link_override_cfg_reg[icfm_pkg::BIT_SWAP_FIX_DIS];
    wire link_rdy_ovr = link_override_cfg_reg[icfm_pkg::BIT_LINK_RDY_OVR];
    wire clock_present_override =
        link_override_cfg_reg[icfm_pkg::BIT_CLK_PRES_OVR];
    wire [1:0] stability_window_sel = link_override_cfg_reg[4:3];
    wire [2:0] measure_hysteresis_mhz = link_override_cfg_reg[2:0];
    wire [5:0] min_clock_mhz = low_limit_reg[5:0];
    wire [6:0] max_clock_mhz = high_limit_reg;
    wire phy_rst_mode = low_limit_reg[icfm_pkg::BIT_PHY_RST_MODE];

    // ------------------------------------------------------------------
    // pin synchronisers: three stages, change counts when 2 and 3 agree
    // ------------------------------------------------------------------
    logic [2:0] s_raw, s_pll, s_5v, s_bc, s_sw, s_prc, s_msel;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_raw <= 3'h0;
            s_pll <= 3'h0;
            s_5v <= 3'h0;
            s_bc <= 3'h0;
            s_sw <= 3'h0;
            s_prc <= 3'h7;
            s_msel <= 3'h0;
        end else begin
            s_raw <= {s_raw[1:0], raw_clk_tick};
            s_pll <= {s_pll[1:0], pll_clk_tick};
            s_5v <= {s_5v[1:0], plus5v_det};
            s_bc <= {s_bc[1:0], back_channel_det};
            s_sw <= {s_sw[1:0], swap_detected};
            s_prc <= {s_prc[1:0], pll_reset_on_change};
            s_msel <= {s_msel[1:0], meter_source_sel};
        end
    end
    // level pins: a change is taken once stages 2 and 3 agree, else held
    wire [4:0] lvl_s2 = {s_5v[1], s_bc[1], s_sw[1], s_prc[1], s_msel[1]};
    wire [4:0] lvl_s3 = {s_5v[2], s_bc[2], s_sw[2], s_prc[2], s_msel[2]};
    logic [4:0] lvl_reg;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) lvl_reg <= 5'b0_0010;
        else lvl_reg <= (lvl_s2 & lvl_s3) | (lvl_reg & (lvl_s2 | lvl_s3));
    end
    wire pin_5v = lvl_reg[4];
    wire pin_bc = lvl_reg[3];
    wire pin_sw = lvl_reg[2];
    wire pin_prc = lvl_reg[1];
    // rising edge of the chosen tick, seen on stages 2 and 3 only
    wire msel = lvl_reg[0];
    wire [2:0] s_tick = msel ? s_pll : s_raw;
    logic tick_d;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) tick_d <= 1'b0;
        else if (s_tick[2] == s_tick[1]) tick_d <= s_tick[2];
    end
    wire tick_rise = (s_tick[2] == s_tick[1]) && s_tick[2] && !tick_d;

    // ------------------------------------------------------------------
    // rate counting: ticks in one microsecond give MHz
    // ------------------------------------------------------------------
    logic [7:0] gate_cnt_reg;
    logic [7:0] tick_cnt_reg;
    wire gate_end = (gate_cnt_reg == 8'(icfm_pkg::MEAS_CYC - 1));
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            gate_cnt_reg <= 8'h00;
            tick_cnt_reg <= 8'h00;
        end else begin
            gate_cnt_reg <= gate_end ? 8'h00 : gate_cnt_reg + 8'h01;
            if (gate_end) tick_cnt_reg <= {7'h00, tick_rise};
            else if (tick_rise && tick_cnt_reg != 8'hff)
                tick_cnt_reg <= tick_cnt_reg + 8'h01;
        end
    end
    // each tick phase needs two agreeing samples, so only rates below a
    // quarter of sys_clk resolve;
    // the bridge supplies a divided tick for faster inputs
    wire [7:0] sample_mhz = tick_cnt_reg;

    // ------------------------------------------------------------------
    // hysteresis, stability and limits
    // ------------------------------------------------------------------
    wire [7:0] diff = (sample_mhz > measured_clock_mhz_reg) ?
        sample_mhz - measured_clock_mhz_reg :
        measured_clock_mhz_reg - sample_mhz;
    wire outside_band = diff > {5'h00, measure_hysteresis_mhz};
    wire capture = gate_end && outside_band;
    // limits judge the held rate: the live count is partial mid-gate
    wire too_slow = measured_clock_mhz_reg < {2'h0, min_clock_mhz};
    wire too_fast = measured_clock_mhz_reg > {1'b0, max_clock_mhz};

    wire [31:0] stbl_limit = (stability_window_sel == 2'b00) ?
        icfm_pkg::STBL_CYC_0 : (stability_window_sel == 2'b01) ?
        icfm_pkg::STBL_CYC_1 : (stability_window_sel == 2'b10) ?
        icfm_pkg::STBL_CYC_2 : STBL_CYC_3;
    logic [15:0] stbl_cnt_reg;
    logic stable_reg;
    wire stbl_done = {16'h0000, stbl_cnt_reg} >= stbl_limit - 32'd1;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            stbl_cnt_reg <= 16'h0000;
            stable_reg <= 1'b0;
        end else if (capture) begin
            stbl_cnt_reg <= 16'h0000;
            stable_reg <= 1'b0;
        end else if (stbl_done) begin
            stable_reg <= 1'b1;
        end else begin
            stbl_cnt_reg <= stbl_cnt_reg + 16'h0001;
        end
    end
    wire in_range = !too_slow && !too_fast;
    wire clk_valid_next = clock_present_override ||
        (stable_reg && in_range && measured_clock_mhz_reg != 8'h00);

    // ------------------------------------------------------------------
    // register writes and measurement
    // ------------------------------------------------------------------
    wire wr_cfg = reg_req.wr && reg_req.addr == icfm_pkg::ADDR_LINK_CFG;
    wire wr_low = reg_req.wr && reg_req.addr == icfm_pkg::ADDR_LOW_LIM;
    wire wr_high = reg_req.wr && reg_req.addr == icfm_pkg::ADDR_HIGH_LIM;
    // swap state has no own register here; software writes it through bit 7
    // of the measured-rate address only while auto fix is off
    wire wr_swap = reg_req.wr && reg_req.addr == icfm_pkg::ADDR_MEAS &&
        swap_fix_dis;
    wire no_signal = gate_end && sample_mhz == 8'h00;
    wire [7:0] meas_next = no_signal ? 8'h00 :
        capture ? sample_mhz : measured_clock_mhz_reg;
    wire freq_change = capture;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            link_override_cfg_reg <= icfm_pkg::RST_LINK_CFG;
            low_limit_reg <= icfm_pkg::RST_LOW_LIM[6:0];
            high_limit_reg <= icfm_pkg::RST_HIGH_LIM[6:0];
            measured_clock_mhz_reg <= icfm_pkg::RST_MEAS;
            swap_state_reg <= 1'b0;
        end else begin
            if (wr_cfg) link_override_cfg_reg <= reg_req.wdata;
            if (wr_low) low_limit_reg <= reg_req.wdata[6:0];
            if (wr_high) high_limit_reg <= reg_req.wdata[6:0];
            measured_clock_mhz_reg <= meas_next;
            if (!swap_fix_dis) swap_state_reg <= pin_sw;
            else if (wr_swap) swap_state_reg <= reg_req.wdata[7];
        end
    end

    // ------------------------------------------------------------------
    // read data and status outputs
    // ------------------------------------------------------------------
    wire [7:0] rd_mux =
        (reg_req.addr == icfm_pkg::ADDR_LINK_CFG) ? link_override_cfg_reg :
        (reg_req.addr == icfm_pkg::ADDR_LOW_LIM) ? {1'b0, low_limit_reg} :
        (reg_req.addr == icfm_pkg::ADDR_HIGH_LIM) ? {1'b0, high_limit_reg} :
        (reg_req.addr == icfm_pkg::ADDR_MEAS) ? measured_clock_mhz_reg :
        8'h00;
    wire phy_rst_next = freq_change && !(phy_rst_mode && pin_5v);
    wire pll_rst_next = freq_change && pin_prc;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= 8'h00;
            status_reg <= '0;
        end else begin
            rdata_reg <= reg_req.rd ? rd_mux : 8'h00;
            status_reg.clk_valid <= clk_valid_next;
            status_reg.link_ready <= link_rdy_ovr || pin_bc;
            status_reg.swap_state <= swap_state_reg;
            status_reg.phy_reset <= phy_rst_next;
            status_reg.pll_reset <= pll_rst_next;
            status_reg.meter_sel <= msel;
        end
    end
    assign reg_rdata = rdata_reg;
    assign status = status_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    override_valid_a: assert property (
        clock_present_override |=> status.clk_valid)
        else $error("override did not force clock valid");
    link_override_a: assert property (
        link_rdy_ovr |=> status.link_ready)
        else $error("link ready override ignored");
    valid_needs_range_a: assert property (
        status.clk_valid && !$past(clock_present_override) |->
        $past(stable_reg && in_range))
        else $error("clock valid without stable in-range rate");
    hyst_capture_a: assert property (
        gate_end && !outside_band && sample_mhz != 8'h00 |=>
        $stable(measured_clock_mhz_reg))
        else $error("capture inside hysteresis band");
    meas_zero_a: assert property (
        no_signal |=> measured_clock_mhz_reg == 8'h00)
        else $error("rate not zero without signal");
    stable_clear_a: assert property (
        capture |=> !stable_reg ##1 !stable_reg)
        else $error("stable kept across capture");
    phy_skip_a: assert property (
        phy_rst_mode && pin_5v |=> !status.phy_reset)
        else $error("phy reset despite +5V policy");
    pll_reset_a: assert property (
        freq_change && pin_prc |=> status.pll_reset)
        else $error("pll reset missing on change");
    reserved_zero_a: assert property (
        reg_req.rd && reg_req.addr == icfm_pkg::ADDR_HIGH_LIM |=>
        !reg_rdata[7])
        else $error("reserved bit read as one");
    swap_lock_a: assert property (
        !swap_fix_dis && !$past(swap_fix_dis) |->
        swap_state_reg == $past(pin_sw))
        else $error("swap state not following auto fix");
    cov_capture_c: cover property (capture);
    cov_valid_c: cover property (!status.clk_valid ##1 status.clk_valid);
    cov_phy_c: cover property (status.phy_reset);
endmodule // icfm_monitor

// ==== tb/icfm_video_src.sv ====
// upstream video source model driving the monitored clock pins
`timescale 1ns/10ps
module icfm_video_src (
    // rate set by the bench, 0 stops the clock
    input wire logic [7:0] freq_mhz,
    // clock pins toward the monitor
    output logic raw_tick,
    output logic pll_tick
);
    // a stopped source parks low, it does not keep toggling
    initial begin
        raw_tick = 1'b0;
        // start off the sampling grid so no tick edge meets a sys_clk edge
        #3;
        forever begin
            if (freq_mhz == 8'h00) begin
                raw_tick = 1'b0;
                #40;
            end else begin
                #(500.0 / freq_mhz);
                raw_tick = ~raw_tick;
            end
        end
    end
    // pll copy lags the raw clock, so the two are never in phase
    initial pll_tick = 1'b0;
    always @(raw_tick) pll_tick <= #6 raw_tick;
endmodule // icfm_video_src

// ==== tb/test_input_clock_freq_monitor.sv ====
// self-checking bench for the input clock frequency monitor
`timescale 1ns/10ps
module test_input_clock_freq_monitor;
    logic sys_clk;
    logic rst_b;
    icfm_pkg::icfm_req_t req;
    logic [7:0] rdata;
    icfm_pkg::icfm_stat_t stat;
    logic raw_tick;
    logic pll_tick;
    logic plus5v;
    logic back_ch;
    logic swap_det;
    logic pll_pol;
    logic msel;
    logic [7:0] freq;
    logic [7:0] rv;
    int n_fail = 0;
    int checks = 0;
    int n_phy = 0;
    int n_pll = 0;

    icfm_monitor #(.STBL_CYC_3(200)) dut_u (.sys_clk(sys_clk),
        .rst_b(rst_b), .reg_req(req), .reg_rdata(rdata),
        .raw_clk_tick(raw_tick), .pll_clk_tick(pll_tick),
        .plus5v_det(plus5v), .back_channel_det(back_ch),
        .swap_detected(swap_det), .pll_reset_on_change(pll_pol),
        .meter_source_sel(msel), .status(stat));
    icfm_video_src src_u (.freq_mhz(freq), .raw_tick(raw_tick),
        .pll_tick(pll_tick));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (stat.phy_reset === 1'b1) n_phy++;
        if (stat.pll_reset === 1'b1) n_pll++;
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp,
                         input string msg);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= d;
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask
    // read data is registered, so it is taken one edge after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge sys_clk);
        req.rd <= 1'b0;
        @(negedge sys_clk);
        check(rdata, e, "read data");
    endtask
    task automatic wait_valid(input logic want, input int lim);
        int i;
        for (i = 0; i < lim && stat.clk_valid !== want; i++)
            @(negedge sys_clk);
        checks++;
        if (stat.clk_valid !== want) begin
            n_fail++;
            $display("[ERR] %0t clock valid wait timed out", $time);
            report_and_stop();
        end
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rd_chk(8'h5c, 8'h02);
        rd_chk(8'h5d, 8'h06);
        rd_chk(8'h5e, 8'h2c);
        rd_chk(8'h5f, 8'h00);
        rd_chk(8'h40, 8'h00);
        check({7'h0, stat.clk_valid}, 8'h00, "valid at reset");
        $display("test reset done");
    endtask
    task automatic t_limits;
        wr_reg(8'h5d, 8'hff);
        wr_reg(8'h5e, 8'hff);
        rd_chk(8'h5d, 8'h7f);
        rd_chk(8'h5e, 8'h7f);
        wr_reg(8'h5d, 8'h06);
        wr_reg(8'h5e, 8'h2c);
        $display("test limits done");
    endtask
    task automatic t_override;
        swap_det <= 1'b1;
        msel <= 1'b1;
        repeat (10) @(posedge sys_clk);
        check({7'h0, stat.swap_state}, 8'h01, "auto swap");
        check({7'h0, stat.meter_sel}, 8'h01, "meter select");
        wr_reg(8'h5c, 8'he0);
        wr_reg(8'h5f, 8'h00);
        repeat (5) @(posedge sys_clk);
        check({7'h0, stat.swap_state}, 8'h00, "swap write");
        check({7'h0, stat.link_ready}, 8'h01, "link forced");
        check({7'h0, stat.clk_valid}, 8'h01, "clock forced");
        wr_reg(8'h5c, 8'h02);
        swap_det <= 1'b0;
        msel <= 1'b0;
        repeat (10) @(posedge sys_clk);
        check({7'h0, stat.link_ready}, 8'h00, "link released");
        check({7'h0, stat.meter_sel}, 8'h00, "meter raw");
        wait_valid(1'b0, 20);
        $display("test override done");
    endtask
    task automatic t_stable;
        // each tick phase needs two samples, so rates stay low; settle
        // with zero hysteresis so a partial first gate cannot stick
        wr_reg(8'h5d, 8'h02);
        wr_reg(8'h5c, 8'h08);
        freq = 8'h05;
        repeat (100) @(posedge sys_clk);
        rd_chk(8'h5f, 8'h05);
        wr_reg(8'h5c, 8'h0a);
        freq = 8'h04;
        repeat (100) @(posedge sys_clk);
        rd_chk(8'h5f, 8'h05);
        freq = 8'h05;
        repeat (900) @(posedge sys_clk);
        check({7'h0, stat.clk_valid}, 8'h00, "valid too early");
        wait_valid(1'b1, 1500);
        wr_reg(8'h5d, 8'h06);
        wait_valid(1'b0, 100);
        wr_reg(8'h5d, 8'h02);
        wait_valid(1'b1, 10);
        wr_reg(8'h5e, 8'h04);
        wait_valid(1'b0, 10);
        wr_reg(8'h5e, 8'h2c);
        wait_valid(1'b1, 10);
        $display("test stability done");
    endtask
    task automatic t_change;
        n_phy = 0;
        n_pll = 0;
        freq = 8'h02;
        repeat (300) @(posedge sys_clk);
        check({7'h0, n_phy > 0}, 8'h01, "phy reset on change");
        check({7'h0, n_pll > 0}, 8'h01, "pll reset on change");
        wr_reg(8'h5d, 8'h42);
        plus5v <= 1'b1;
        repeat (10) @(posedge sys_clk);
        n_phy = 0;
        n_pll = 0;
        freq = 8'h05;
        repeat (300) @(posedge sys_clk);
        check({7'h0, n_phy > 0}, 8'h00, "phy reset kept off");
        check({7'h0, n_pll > 0}, 8'h01, "pll reset again");
        wr_reg(8'h5d, 8'h06);
        plus5v <= 1'b0;
        $display("test change done");
    endtask
    task automatic t_lost;
        freq = 8'h00;
        repeat (300) @(posedge sys_clk);
        rd_chk(8'h5f, 8'h00);
        wait_valid(1'b0, 50);
        $display("test lost clock done");
    endtask

    initial begin
        rst_b = 1'b0;
        req = '0;
        plus5v = 1'b0;
        back_ch = 1'b0;
        swap_det = 1'b0;
        pll_pol = 1'b1;
        msel = 1'b0;
        freq = 8'h00;
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_reset();
        t_limits();
        t_override();
        t_stable();
        t_change();
        t_lost();
        report_and_stop();
    end
endmodule // test_input_clock_freq_monitor
